// ---- hdl/cmsb_cfg.svh ----
/*
  offsets, field positions, reset values and counts for the
  configuration manager status block; included by design modules.
*/
`ifndef CMSB_CFG_SVH
`define CMSB_CFG_SVH
// register byte addresses
`define CMSB_OFS_STATUS   8'h04
`define CMSB_OFS_CONTROL  8'h10
// status field positions
`define CMSB_BIT_PRESENT  4
`define CMSB_BIT_BUFRDY   5
`define CMSB_BIT_BUFDIR   6
`define CMSB_BIT_DONE     7
`define CMSB_BIT_CMDRDY   8
`define CMSB_BIT_AUTOPIN  9
`define CMSB_LSB_IMGSEL   13
`define CMSB_BIT_BUSY     17
`define CMSB_BIT_CRDY     18
`define CMSB_BIT_DWF      19
// control field positions
`define CMSB_BIT_OVR_EN   0
`define CMSB_BIT_OVR_VAL  1
`define CMSB_BIT_LAUNCH   2
// reset values
`define CMSB_RST_CONTROL  2'h0
`define CMSB_RST_PINS     8'h00
// cycles for the pin synchroniser to settle after reset
`define CMSB_SETTLE_CYC   3'h4
`endif

// ---- hdl/cmsb_pkg.sv ----
/*
  types shared by the configuration manager status block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package cmsb_pkg;
  typedef logic [31:0] cmsb_word_t;
  typedef logic [7:0]  cmsb_addr_t;
  typedef enum logic [1:0] {
    CMSB_SETTLE,
    CMSB_HOLD,
    CMSB_RUN,
    CMSB_DONE
  } cmsb_state_e;
endpackage

// ---- hdl/cmsb_seq_if.sv ----
/*
  link between the register side and the start sequencer.
  assumes a single clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
interface cmsb_seq_if;
  logic auto_en;   // effective autostart selection
  logic launch;    // software start pulse
  logic finished;  // configuration engine finished
  logic start;     // start pulse to the engine
  logic done;      // configuration complete level
  modport seq (input auto_en, launch, finished, output start, done);
  modport regs (output auto_en, launch, finished, input start, done);
endinterface
`default_nettype wire

// ---- hdl/cmsb_pin_sync.sv ----
/*
  three-stage synchroniser for pin inputs with agree filter.
  assumes inputs are asynchronous to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module cmsb_pin_sync
  import cmsb_pkg::*;
(
  input  wire logic       clk_i,    // system clock
  input  wire logic       reset_i,  // sync reset, high
  input  wire logic [7:0] pins_i,   // raw pin levels
  output logic      [7:0] pins_o    // filtered levels
);
`include "cmsb_cfg.svh"
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] s3_ff;
  // stage one is seen by stage two only
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_ff <= `CMSB_RST_PINS;
      s2_ff <= `CMSB_RST_PINS;
      s3_ff <= `CMSB_RST_PINS;
    end else begin
      s1_ff <= pins_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  // a bit moves only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pins_o <= `CMSB_RST_PINS;
    end else begin
      pins_o <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & pins_o);
    end
  end
endmodule
`default_nettype wire

// ---- hdl/cmsb_start_seq.sv ----
/*
  start sequencer: autostart or software launch, then done.
  assumes the engine pulses finished once per start.
*/
`timescale 1ns/10ps
`default_nettype none
module cmsb_start_seq
  import cmsb_pkg::*;
(
  input  wire logic clk_i,    // system clock
  input  wire logic reset_i,  // sync reset, high
  cmsb_seq_if.seq   sq        // sequencer side
);
`include "cmsb_cfg.svh"
  cmsb_state_e state_ff;
  logic [2:0]  wait_ff;
  // settle lets the synchronised pin become valid first
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wait_ff <= '0;
    end else if (state_ff == CMSB_SETTLE) begin
      wait_ff <= wait_ff + 3'h1;
    end
  end
  // state walk
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= CMSB_SETTLE;
    end else begin
      unique case (state_ff)
        CMSB_SETTLE: begin
          if (wait_ff == `CMSB_SETTLE_CYC) begin
            state_ff <= sq.auto_en ? CMSB_RUN : CMSB_HOLD; // [R7]
          end
        end
        CMSB_HOLD: begin
          if (sq.launch) begin
            state_ff <= CMSB_RUN; // [R8]
          end
        end
        CMSB_RUN: begin
          if (sq.finished) begin
            state_ff <= CMSB_DONE; // [R5]
          end
        end
        CMSB_DONE: begin
          state_ff <= CMSB_DONE;
        end
      endcase
    end
  end
  // start pulses on entering run
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sq.start <= 1'b0;
    end else begin
      sq.start <= ((state_ff == CMSB_SETTLE) && (wait_ff == `CMSB_SETTLE_CYC)
                   && sq.auto_en) || ((state_ff == CMSB_HOLD) && sq.launch);
    end
  end
  assign sq.done = (state_ff == CMSB_DONE); // [R5]
endmodule
`default_nettype wire

// ---- hdl/cmsb_status.sv ----
/*
  configuration manager status bits 4..19 with control register.
  assumes a simple strobe register port and an external
  configuration engine that pulses config_finished_i.
*/
// How it works
// [R1] bit 4 is one while a storage card is present
// [R2] bit 5 is one when the sector buffer can move data
// [R3] bit 6 is one while the buffer is in write-only mode
// [R4] bit 6 is zero while the buffer is in read mode
// [R5] bit 7 sets only after the whole configuration has finished
// [R6] bit 8 is one when the card controller takes a new command
// [R7] bit 9 shows the autostart pin; one starts configuration after reset
// [R8] with the pin low, configuration waits for the launch bit
// [R9] a control override replaces the pin choice; bit 9 still shows the pin
// [R10] bits 13 to 15 mirror the three image select pins
// [R11] bit 17 mirrors the card busy flag
// [R12] host leaves card command and buffer alone while busy is one
// [R13] host ignores status bits 1 to 6 while busy is one
// [R14] bit 18 mirrors the card ready flag
// [R15] bit 19 mirrors the card write fault flag
// [R16] host reads this register to find an interrupt source
// [R17] reserved bits read zero; status writes have no effect
`timescale 1ns/10ps
`default_nettype none
module cmsb_status
  import cmsb_pkg::*;
(
  input  wire logic       clk_i,              // 40 MHz clock
  input  wire logic       reset_i,            // sync reset, high
  input  wire logic [7:0] addr_i,             // register byte address
  input  wire logic [31:0] wr_data_i,         // write data
  input  wire logic       wr_en_i,            // write strobe
  input  wire logic       rd_en_i,            // read strobe
  output logic      [31:0] rd_data_o,         // read data, next cycle
  input  wire logic       card_present_i,     // card detect pin
  input  wire logic       autostart_pin_i,    // autostart mode pin
  input  wire logic [2:0] image_select_pin_i, // image select pins
  input  wire logic       card_busy_i,        // card busy flag
  input  wire logic       card_ready_i,       // card ready flag
  input  wire logic       card_wfault_i,      // card write fault
  input  wire logic       buf_ready_i,        // sector buffer ready
  input  wire logic       buf_write_mode_i,   // buffer write-only
  input  wire logic       cmd_ready_i,        // card ctrl takes cmd
  input  wire logic       config_finished_i,  // engine done pulse
  output logic            config_start_o,     // engine start pulse
  output logic            config_done_o       // configuration done
);
`include "cmsb_cfg.svh"

  logic [7:0] pins_q;
  logic [1:0] control_ff;
  logic       autostart_override;
  logic       auto_val;

  cmsb_seq_if sq ();

  // pins and card flags are asynchronous; one filtered bank
  cmsb_pin_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pins_i  ({card_wfault_i, card_ready_i, card_busy_i,
               image_select_pin_i, autostart_pin_i,
               card_present_i}),
    .pins_o  (pins_q)
  );

  // filtered pin fields
  logic       card_present_flag;
  logic       autostart_pin_state;
  logic [2:0] image_sel;
  logic       card_busy_mirror;
  logic       card_ready_mirror;
  logic       card_write_fault_mirror;
  assign card_present_flag       = pins_q[0];
  assign autostart_pin_state     = pins_q[1];
  assign image_sel               = pins_q[4:2];
  assign card_busy_mirror        = pins_q[5];
  assign card_ready_mirror       = pins_q[6];
  assign card_write_fault_mirror = pins_q[7];

  // address decode
  logic hit_status;
  logic hit_control;
  assign hit_status  = (addr_i == `CMSB_OFS_STATUS);
  assign hit_control = (addr_i == `CMSB_OFS_CONTROL);

  // control register: override enable and value
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      control_ff <= `CMSB_RST_CONTROL;
    end else if (wr_en_i && hit_control) begin
      control_ff <= {wr_data_i[`CMSB_BIT_OVR_VAL],
                     wr_data_i[`CMSB_BIT_OVR_EN]};
    end
  end
  assign autostart_override = control_ff[0];
  assign auto_val           = control_ff[1];

  // override replaces the pin for the start choice only
  assign sq.auto_en = autostart_override ? auto_val
                                         : autostart_pin_state; // [R9] [R7]
  // launch bit is a write pulse, never stored
  assign sq.launch  = wr_en_i && hit_control
                      && wr_data_i[`CMSB_BIT_LAUNCH]; // [R8]
  assign sq.finished = config_finished_i;

  cmsb_start_seq u_seq (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .sq      (sq.seq)
  );

  assign config_start_o = sq.start;
  assign config_done_o  = sq.done;

  // gather the status word; bits outside 4..19 stay zero
  function automatic cmsb_word_t status_word(
    input logic [7:0] pins,
    input logic       bufrdy,
    input logic       bufwr,
    input logic       done,
    input logic       cmdrdy
  );
    cmsb_word_t w;
    w = '0;                                            // [R17]
    w[`CMSB_BIT_PRESENT] = pins[0];                    // [R1]
    w[`CMSB_BIT_BUFRDY]  = bufrdy;                     // [R2]
    w[`CMSB_BIT_BUFDIR]  = bufwr;                      // [R3] [R4]
    w[`CMSB_BIT_DONE]    = done;                       // [R5]
    w[`CMSB_BIT_CMDRDY]  = cmdrdy;                     // [R6]
    w[`CMSB_BIT_AUTOPIN] = pins[1];                    // [R7] [R9]
    w[`CMSB_LSB_IMGSEL +: 3] = pins[4:2];              // [R10]
    w[`CMSB_BIT_BUSY]    = pins[5];                    // [R11]
    w[`CMSB_BIT_CRDY]    = pins[6];                    // [R14]
    w[`CMSB_BIT_DWF]     = pins[7];                    // [R15]
    return w;
  endfunction

  cmsb_word_t status_now;
  assign status_now = status_word({card_write_fault_mirror, card_ready_mirror,
                                   card_busy_mirror, image_sel,
                                   autostart_pin_state, card_present_flag},
                                  buf_ready_i, buf_write_mode_i,
                                  sq.done, cmd_ready_i);

  // read mux; unmapped and idle cycles return zero
  // status writes fall through here with no effect
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i && hit_status) begin
      rd_data_o <= status_now;
    end else if (rd_en_i && hit_control) begin
      rd_data_o <= {30'h0, control_ff};
    end else begin
      rd_data_o <= '0; // [R17]
    end
  end

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  logic [7:0] past_pins;
  logic       past_done;
  always_ff @(posedge clk_i) begin
    past_pins <= pins_q;
    past_done <= sq.done;
  end

  // start count for the once-per-reset checks, saturating
  logic [1:0] start_cnt_ff;
  logic [1:0] past_ctl_wr;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      start_cnt_ff <= 2'h0;
    end else if (sq.start && start_cnt_ff != 2'h3) begin
      start_cnt_ff <= start_cnt_ff + 2'h1;
    end
  end
  // override bits offered in the last cycle
  always_ff @(posedge clk_i) begin
    past_ctl_wr <= {wr_data_i[`CMSB_BIT_OVR_VAL], wr_data_i[`CMSB_BIT_OVR_EN]};
  end

  a_present_bit: assert property ( // [R1]
    rd_en_i && hit_status |=> rd_data_o[4] == past_pins[0])
    else $error("present bit wrong");

  a_bufrdy_bit: assert property ( // [R2]
    rd_en_i && hit_status |=> rd_data_o[5] == $past(buf_ready_i))
    else $error("buffer ready bit wrong");

  a_dir_write: assert property ( // [R3]
    rd_en_i && hit_status && buf_write_mode_i |=> rd_data_o[6])
    else $error("write mode not shown");

  a_dir_read: assert property ( // [R4]
    rd_en_i && hit_status && !buf_write_mode_i |=> !rd_data_o[6])
    else $error("read mode not shown");

  a_done_order: assert property ( // [R5]
    $rose(sq.done) |-> $past(sq.finished) && !$past(sq.done))
    else $error("done rose without finish");

  a_done_bit: assert property ( // [R5]
    rd_en_i && hit_status |=> rd_data_o[7] == past_done)
    else $error("done bit wrong");

  a_cmd_ready: assert property ( // [R6]
    rd_en_i && hit_status |=> rd_data_o[8] == $past(cmd_ready_i))
    else $error("command ready bit wrong");

  a_pin_mirror: assert property ( // [R7] [R9] [R10]
    rd_en_i && hit_status |=>
      rd_data_o[9] == past_pins[1] && rd_data_o[15:13] == past_pins[4:2])
    else $error("pin mirror wrong");

  a_hold_off: assert property ( // [R8]
    sq.start |-> $past(sq.launch) || $past(sq.auto_en))
    else $error("start without cause");

  a_launch_go: assert property ( // [R8]
    sq.launch && !sq.done && !config_start_o && !sq.auto_en
      && !$past(sq.auto_en) && !$past(sq.start) && !$past(sq.start, 2)
      && $past(u_seq.state_ff) == CMSB_HOLD
    |=> config_start_o)
    else $error("launch ignored");

  a_card_flags: assert property ( // [R11] [R14] [R15]
    rd_en_i && hit_status |=> rd_data_o[19:17] == past_pins[7:5])
    else $error("card flag mirror wrong");

  a_reserved_zero: assert property ( // [R17]
    rd_en_i && hit_status |=>
      rd_data_o[12:10] == 3'h0 && !rd_data_o[16]
      && rd_data_o[3:0] == 4'h0 && rd_data_o[31:20] == 12'h000)
    else $error("reserved bits set");

  a_idle_zero: assert property ( // [R17]
    !rd_en_i |=> rd_data_o == '0)
    else $error("read data outside read slot");

  // start is a single-cycle pulse
  a_start_pulse: assert property ( // [R7] [R8]
    sq.start |=> !sq.start)
    else $error("start pulse too long");

  // one start per reset, however often launch is written
  a_start_once: assert property ( // [R7] [R8]
    start_cnt_ff < 2'h2)
    else $error("second start after reset");

  // no start while the synchronised pin may still be settling
  a_settle_quiet: assert property ( // [R7] [R8]
    u_seq.state_ff == CMSB_SETTLE |-> !sq.start)
    else $error("start during settle");

  // settle end takes the effective choice, pin or override
  a_auto_choice: assert property ( // [R7] [R9]
    u_seq.state_ff == CMSB_SETTLE && u_seq.wait_ff == `CMSB_SETTLE_CYC
    |=> sq.start == $past(sq.auto_en))
    else $error("autostart choice not taken");

  // holding waits for the launch bit alone
  a_hold_waits: assert property ( // [R8]
    u_seq.state_ff == CMSB_HOLD && !sq.launch |=> u_seq.state_ff == CMSB_HOLD)
    else $error("left hold without launch");

  // complete stays complete and never restarts before reset
  a_done_stays: assert property ( // [R5]
    sq.done |=> sq.done && !sq.start)
    else $error("done dropped or restarted");

  // done needs a start earlier in this reset period
  a_done_after_start: assert property ( // [R5]
    sq.done |-> start_cnt_ff != 2'h0)
    else $error("done without start");

  // control keeps the two override bits written
  a_ctl_capture: assert property ( // [R9]
    wr_en_i && hit_control |=> control_ff == past_ctl_wr)
    else $error("control write lost");

  // control reads back the override bits, launch reads zero
  a_ctl_read: assert property ( // [R9]
    rd_en_i && hit_control |=> rd_data_o == {30'h0, $past(control_ff)})
    else $error("control read wrong");

  // a status write leaves the control bits alone
  a_status_ro: assert property ( // [R17]
    wr_en_i && hit_status |=> $stable(control_ff))
    else $error("status write took effect");

  // unmapped reads return zero
  a_unmapped_zero: assert property ( // [R17]
    rd_en_i && !hit_status && !hit_control |=> rd_data_o == '0)
    else $error("unmapped read not zero");

  // a filtered bit moves only once both late stages agree
  a_sync_agree: assert property ( // [R1] [R10] [R11]
    ((pins_q ^ $past(pins_q)) & ($past(u_sync.s2_ff) ^ $past(u_sync.s3_ff))) == 8'h00)
    else $error("pin moved before stages agreed");

  // a moved bit takes the agreed level
  a_sync_level: assert property ( // [R14] [R15]
    ((pins_q ^ $past(pins_q)) & (pins_q ^ $past(u_sync.s3_ff))) == 8'h00)
    else $error("pin took a level not agreed");

  // a steady detect pin reaches its flag through the filter
  a_present_follow: assert property ( // [R1]
    $stable(card_present_i) [*4] |=> card_present_flag == $past(card_present_i))
    else $error("present flag stale");

  // a steady mode pin reaches its mirror
  a_autopin_follow: assert property ( // [R7] [R9]
    $stable(autostart_pin_i) [*4] |=> autostart_pin_state == $past(autostart_pin_i))
    else $error("autostart pin mirror stale");

  // steady image select pins reach their mirror
  a_image_follow: assert property ( // [R10]
    $stable(image_select_pin_i) [*4] |=> image_sel == $past(image_select_pin_i))
    else $error("image select mirror stale");

  // a steady busy flag reaches its mirror
  a_busy_follow: assert property ( // [R11]
    $stable(card_busy_i) [*4] |=> card_busy_mirror == $past(card_busy_i))
    else $error("busy mirror stale");

  // a steady ready flag reaches its mirror
  a_ready_follow: assert property ( // [R14]
    $stable(card_ready_i) [*4] |=> card_ready_mirror == $past(card_ready_i))
    else $error("ready mirror stale");

  // a steady write fault flag reaches its mirror
  a_fault_follow: assert property ( // [R15]
    $stable(card_wfault_i) [*4] |=> card_write_fault_mirror == $past(card_wfault_i))
    else $error("write fault mirror stale");

  c_autostart: cover property (
    sq.start && $past(u_seq.state_ff) == CMSB_SETTLE);
  c_launch: cover property (
    sq.launch ##1 sq.start);
  c_done_read: cover property (
    sq.done && rd_en_i && hit_status);
  c_busy_seen: cover property (
    card_busy_mirror && rd_en_i && hit_status);
  c_status_write: cover property (
    wr_en_i && hit_status);

endmodule
`default_nettype wire

// ---- dv/cmsb_host.sv ----
/*
  host model on the register port: strobed reads and writes.
  assumes the block answers a read one cycle after its strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module cmsb_host
  import cmsb_pkg::*;
(
  input  wire logic       clk_i,     // system clock
  input  wire cmsb_word_t rd_data_i, // read data
  output var cmsb_addr_t  addr_o,    // byte address
  output var cmsb_word_t  wr_data_o, // write data
  output logic            wr_en_o,   // write strobe
  output logic            rd_en_o    // read strobe
);
  // bus idle at time zero
  initial begin
    addr_o = 8'h00;
    wr_data_o = 32'h0;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
  end
  // one-cycle write strobe, changed just after an edge
  task automatic wr(input cmsb_addr_t a, input cmsb_word_t d);
    @(posedge clk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_en_o <= 1'b1;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe; take it at that cycle's end
  task automatic rd(input cmsb_addr_t a, output cmsb_word_t d);
    @(posedge clk_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    @(posedge clk_i);
    d = rd_data_i;
  endtask
  // no card command or buffer register sits behind this port
  // no interrupt line here, so status is simply polled
  // while busy reads one, bits 1 to 6 carry no meaning
  function automatic cmsb_word_t trust(input cmsb_word_t w);
    return w[17] ? (w & 32'hffff_ff81) : w;
  endfunction
endmodule
`default_nettype wire

// ---- dv/cmsb_status_tb.sv ----
/*
  self-checking bench for the status block.
  assumes the host model and the design header are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cmsb_cfg.svh"
module cmsb_status_tb;
  import cmsb_pkg::*;
  logic       clk, reset, pin, fin;
  logic [9:0] pv;
  cmsb_addr_t addr;
  cmsb_word_t wdata, rdata, d, e;
  logic       wen, ren, start, done;
  int         mismatches, comparisons, starts;
  logic       cpin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  cmsb_word_t cctl [4] = '{32'h0, 32'h0, 32'h1, 32'h3};
  logic       cauto[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  cmsb_host u_cmsb_host (.clk_i(clk), .rd_data_i(rdata), .addr_o(addr),
    .wr_data_o(wdata), .wr_en_o(wen), .rd_en_o(ren));
  cmsb_status u_cmsb_status (.clk_i(clk), .reset_i(reset), .addr_i(addr),
    .wr_data_i(wdata), .wr_en_i(wen), .rd_en_i(ren), .rd_data_o(rdata),
    .card_present_i(pv[0]), .autostart_pin_i(pin), .image_select_pin_i(pv[6:4]),
    .card_busy_i(pv[7]), .card_ready_i(pv[8]), .card_wfault_i(pv[9]),
    .buf_ready_i(pv[1]), .buf_write_mode_i(pv[2]), .cmd_ready_i(pv[3]),
    .config_finished_i(fin), .config_start_o(start), .config_done_o(done));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // count start pulses seen since the last reset
  always @(posedge clk) begin
    if (start === 1'b1) starts++;
  end
  task automatic chk(input string n, input cmsb_word_t s, input cmsb_word_t e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic cmsb_word_t exp_st(input logic [9:0] p, input logic dn, input logic ap);
    cmsb_word_t w;
    w = 32'h0;
    w[`CMSB_BIT_PRESENT] = p[0];
    w[`CMSB_BIT_BUFRDY] = p[1];
    w[`CMSB_BIT_BUFDIR] = p[2];
    w[`CMSB_BIT_DONE] = dn;
    w[`CMSB_BIT_CMDRDY] = p[3];
    w[`CMSB_BIT_AUTOPIN] = ap;
    w[`CMSB_LSB_IMGSEL +: 3] = p[6:4];
    w[`CMSB_BIT_BUSY] = p[7];
    w[`CMSB_BIT_CRDY] = p[8];
    w[`CMSB_BIT_DWF] = p[9];
    return w;
  endfunction
  task automatic do_reset();
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    starts = 0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(25 * 5000);
    mismatches++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    pin = 1'b0;
    fin = 1'b0;
    pv = 10'h0;
    mismatches = 0;
    comparisons = 0;
    starts = 0;
    // start sequencing for each pin and override setting
    for (int k = 0; k < 4; k++) begin
      pin <= cpin[k];
      do_reset();
      if (cctl[k] !== 32'h0) u_cmsb_host.wr(`CMSB_OFS_CONTROL, cctl[k]);
      repeat (12) @(posedge clk);
      chk("autostart", 32'(starts), {31'h0, cauto[k]});
      u_cmsb_host.wr(`CMSB_OFS_CONTROL, cctl[k] | 32'h4);
      repeat (3) @(posedge clk);
      chk("start count", 32'(starts), 32'h1);
      u_cmsb_host.rd(`CMSB_OFS_CONTROL, d);
      chk("control", d, cctl[k] & 32'h3);
      u_cmsb_host.rd(`CMSB_OFS_STATUS, d);
      chk("status early", d, exp_st(10'h0, 1'b0, cpin[k]));
      @(posedge clk);
      fin <= 1'b1;
      @(posedge clk);
      fin <= 1'b0;
      @(posedge clk);
      chk("done", {31'h0, done}, 32'h1);
      u_cmsb_host.rd(`CMSB_OFS_STATUS, d);
      chk("status done", d, exp_st(10'h0, 1'b1, cpin[k]));
    end
    $display("test start sequencing done");
    // walk each mirrored input but the autostart pin, then all ones and all zeros
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      pv <= (i < 10) ? (10'h1 << i) : ((i == 10) ? 10'h3ff : 10'h0);
      repeat (6) @(posedge clk);
      u_cmsb_host.rd(`CMSB_OFS_STATUS, d);
      e = u_cmsb_host.trust(exp_st(pv, 1'b1, 1'b0));
      d = u_cmsb_host.trust(d);
      chk("status", d, e);
    end
    $display("test mirrors done");
    // status ignores writes; an unmapped place reads zero
    u_cmsb_host.wr(`CMSB_OFS_STATUS, 32'hffff_ffff);
    u_cmsb_host.rd(`CMSB_OFS_STATUS, d);
    chk("status write", d, exp_st(10'h0, 1'b1, 1'b0));
    u_cmsb_host.rd(8'h08, d);
    chk("unmapped", d, 32'h0);
    $display("test write ignore done");
    end_sim();
  end
endmodule
`default_nettype wire
